//--- src/otp_program_verify_port.sv
`timescale 1ns/100ps
`include "otp_cfg.svh"
// What this block does
// - Both locks clear allow everything, lock one blocks memory programming, both also block verify.
// - Code memory reads back for verify only while lock two is unprogrammed.
// - In verify the result byte is driven onto the eight-bit data port.
// - Verify data is the XNOR of the code byte and the table entry picked by the low six address bits.
// - No path exists that reads the encryption table back.
// - With reset high and strobe low, five mode bits choose the operation; programming needs high voltage.
// - Blank code and table bytes hold zero, so a blank byte verifies as all ones.
// - Either lock bit blocks code and table programming but the other lock bit stays programmable.
module otp_program_verify_port
	import otp_pkg::*;
#(
	parameter int        ADDR_W = 15,
	parameter int        TBL_W  = 6,
	parameter logic [7:0] MFR_ID = 8'ha5, // Arbitrary value
	parameter logic [7:0] DEV_ID = 8'h3c  // Arbitrary value
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        prog_reset_i,
	input  wire logic [7:0]  addr_low_port_i,
	input  wire logic [6:0]  addr_high_port_i,
	input  wire logic [7:0]  byte_data_port_i,
	output logic      [7:0]  byte_data_port_o,
	output logic             byte_data_port_oe_o,
	input  wire logic [5:1]  mode_select_port_i,
	input  wire logic        prog_store_strobe_i,
	input  wire logic        prog_pulse_i,
	input  wire logic        high_voltage_test_pin_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int TBL_N = 1 << TBL_W;
	localparam int SYNC_W = 8 + 7 + 8 + 5 + 4;

	// Memory arrays; table has no read path to any port; both start erased to zero
	logic [7:0] code_mem [DEPTH] = '{default: `OTP_ERASED_BYTE};
	logic [7:0] enc_mem  [TBL_N] = '{default: `OTP_ERASED_BYTE};

	// Pin synchronisers
	logic [SYNC_W-1:0] pins_sync;
	otp_pin_sync #(.WIDTH(SYNC_W)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({addr_high_port_i, addr_low_port_i, byte_data_port_i, mode_select_port_i,
			prog_reset_i, prog_store_strobe_i, prog_pulse_i, high_voltage_test_pin_i}),
		.sync_o  (pins_sync)
	);
	logic [ADDR_W-1:0] pin_addr;
	logic [7:0]        pin_data;
	logic [4:0]        pin_mode;
	logic              pin_rst;
	logic              pin_store;
	logic              pin_pulse;
	logic              pin_hv;
	// High port lands above the low port, giving the 15-bit code address
	assign pin_addr  = pins_sync[31:17];
	assign pin_data  = pins_sync[16:9];
	assign pin_mode  = pins_sync[8:4];
	assign pin_rst   = pins_sync[3];
	assign pin_store = pins_sync[2];
	assign pin_pulse = pins_sync[1];
	assign pin_hv    = pins_sync[0];

	// Mode decode, used for the pins only; software reads do not go through it
	function automatic otp_op_type decode_mode(input logic [4:0] m, input logic r, input logic s);
		otp_op_type op;
		op = OTP_OP_NONE;
		if (r && !s) begin
			unique case (m)
				`OTP_MODE_PROG_CODE:  op = OTP_OP_PROG_CODE;
				`OTP_MODE_VERIFY:     op = OTP_OP_VERIFY;
				`OTP_MODE_PROG_ENC:   op = OTP_OP_PROG_ENC;
				`OTP_MODE_LOCK_ONE:   op = OTP_OP_LOCK_ONE;
				`OTP_MODE_LOCK_TWO:   op = OTP_OP_LOCK_TWO;
				`OTP_MODE_SIGNATURE:  op = OTP_OP_SIGNATURE;
				default:              op = OTP_OP_NONE;
			endcase
		end
		return op;
	endfunction

	// Encrypted verify byte
	function automatic logic [7:0] enc_verify(input logic [7:0] code, input logic [7:0] key);
		return ~(code ^ key);
	endfunction

	// Byte-lane write hit on one register
	function automatic logic lane_hit(input logic [3:0] adr, input logic [3:0] sel, input logic [3:0] reg_adr,
		input int lane);
		return (adr == reg_adr) && sel[lane];
	endfunction

	otp_op_type op;
	assign op = decode_mode(pin_mode, pin_rst, pin_store);

	// Lock bits, strobe pulse counter, refused flag, Wishbone regs
	logic              lock_one_reg;
	logic              lock_one_next;
	logic              lock_two_reg;
	logic              lock_two_next;
	logic [4:0]        pulse_cnt_reg;
	logic [4:0]        pulse_cnt_next;
	logic              pulse_prev_reg;
	logic              pulse_prev_next;
	logic [ADDR_W-1:0] op_addr_reg;
	logic [ADDR_W-1:0] op_addr_next;
	otp_op_type        op_reg;
	otp_op_type        op_next;
	logic              refused_reg;
	logic              refused_next;
	logic [ADDR_W-1:0] sw_addr_reg;
	logic [ADDR_W-1:0] sw_addr_next;
	logic [7:0]        sw_data_reg;
	logic [7:0]        sw_data_next;
	logic              ack_reg;
	logic              ack_next;
	logic [31:0]       rdat_reg;
	logic [31:0]       rdat_next;
	logic [7:0]        out_reg;
	logic [7:0]        out_next;
	logic              oe_reg;
	logic              oe_next;

	logic              fall;
	logic              any_lock;
	logic              write_code;
	logic              write_enc;
	logic [4:0]        need;
	logic              refuse_now;
	logic              wb_take;
	logic              wb_commit;

	assign fall      = pulse_prev_reg && !pin_pulse;
	assign any_lock  = lock_one_reg || lock_two_reg;
	// Reads answer at the taking edge; writes land only at the edge that sees ack
	assign wb_take   = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wb_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

	// Pulse target per mode; counting restarts when mode or address moves
	always_comb begin
		unique case (op)
			OTP_OP_PROG_CODE: need = `OTP_PULSES_CODE;
			OTP_OP_PROG_ENC:  need = `OTP_PULSES_ENC;
			OTP_OP_LOCK_ONE,
			OTP_OP_LOCK_TWO:  need = `OTP_PULSES_LOCK;
			default:          need = 5'd0;
		endcase
	end

	// Programming sequencer
	always_comb begin
		lock_one_next   = lock_one_reg;
		lock_two_next   = lock_two_reg;
		pulse_cnt_next  = pulse_cnt_reg;
		pulse_prev_next = pin_pulse;
		op_next         = op;
		op_addr_next    = pin_addr;
		refused_next    = refused_reg;
		write_code      = 1'b0;
		write_enc       = 1'b0;
		refuse_now      = 1'b0;
		// A moved mode or address restarts the count, so a stray pulse never completes a byte
		if (op != op_reg || pin_addr != op_addr_reg) begin
			pulse_cnt_next = 5'd0;
		end else if (fall && need != 5'd0) begin
			if (!pin_hv) begin
				refuse_now = 1'b1;
			end else if (pulse_cnt_reg + 5'd1 == need) begin
				pulse_cnt_next = 5'd0;
				unique case (op)
					OTP_OP_PROG_CODE: begin
						if (any_lock) refuse_now = 1'b1;
						else write_code = 1'b1;
					end
					OTP_OP_PROG_ENC: begin
						if (any_lock) refuse_now = 1'b1;
						else write_enc = 1'b1;
					end
					OTP_OP_LOCK_ONE: lock_one_next = 1'b1;
					OTP_OP_LOCK_TWO: lock_two_next = 1'b1;
					default:         pulse_cnt_next = 5'd0;
				endcase
			end else begin
				pulse_cnt_next = pulse_cnt_reg + 5'd1;
			end
		end
		// Set wins over software clear
		if (refuse_now) begin
			refused_next = 1'b1;
		end else if (wb_commit && lane_hit(wb_adr_i, wb_sel_i, `OTP_REG_CONTROL, 0)
			&& wb_dat_i[`OTP_CTL_REFUSED_CLR]) begin
			refused_next = 1'b0;
		end
	end

	// Memory writes; only a completed pulse train reaches the arrays
	always_ff @(posedge clk_i) begin
		if (write_code) code_mem[pin_addr] <= pin_data;
		if (write_enc)  enc_mem[pin_addr[TBL_W-1:0]] <= pin_data;
	end

	// Pin verify and signature output
	always_comb begin
		out_next = out_reg;
		oe_next  = 1'b0;
		if (op == OTP_OP_VERIFY && !lock_two_reg) begin
			out_next = enc_verify(code_mem[pin_addr], enc_mem[pin_addr[TBL_W-1:0]]);
			oe_next  = 1'b1;
		end else if (op == OTP_OP_SIGNATURE) begin
			out_next = (pin_addr == `OTP_SIG_ADDR_MFR) ? MFR_ID :
				(pin_addr == `OTP_SIG_ADDR_DEV) ? DEV_ID : 8'h00;
			oe_next  = 1'b1;
		end
	end

	// Wishbone slave; read-back is encrypted and lock-gated too
	always_comb begin
		ack_next     = wb_take;
		rdat_next    = rdat_reg;
		sw_addr_next = sw_addr_reg;
		sw_data_next = sw_data_reg;
		// Register writes at the ack edge, while the master still holds the request
		if (wb_commit) begin
			if (lane_hit(wb_adr_i, wb_sel_i, `OTP_REG_ADDR, 0)) begin
				sw_addr_next[7:0] = wb_dat_i[7:0];
			end
			if (lane_hit(wb_adr_i, wb_sel_i, `OTP_REG_ADDR, 1)) begin
				sw_addr_next[ADDR_W-1:8] = wb_dat_i[ADDR_W-1:8];
			end
			if (lane_hit(wb_adr_i, wb_sel_i, `OTP_REG_CONTROL, 0) && wb_dat_i[`OTP_CTL_READ]) begin
				sw_data_next = lock_two_reg ? 8'h00 :
					enc_verify(code_mem[sw_addr_reg], enc_mem[sw_addr_reg[TBL_W-1:0]]);
			end
		end
		// Read data is registered on the taking edge and shown with ack
		if (wb_take) begin
			rdat_next = 32'h0000_0000;
			if (!wb_we_i) begin
				unique case (wb_adr_i)
					`OTP_REG_STATUS: begin
						rdat_next[`OTP_ST_LOCK_ONE] = lock_one_reg;
						rdat_next[`OTP_ST_LOCK_TWO] = lock_two_reg;
						rdat_next[`OTP_ST_REFUSED]  = refused_reg;
					end
					`OTP_REG_ADDR: rdat_next[ADDR_W-1:0] = sw_addr_reg;
					`OTP_REG_DATA: rdat_next[7:0] = sw_data_reg;
					default:       rdat_next = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_one_reg   <= 1'b0;
			lock_two_reg   <= 1'b0;
			pulse_cnt_reg  <= 5'd0;
			pulse_prev_reg <= 1'b0; // Synchroniser resets low too, so no false edge
			op_reg         <= OTP_OP_NONE;
			op_addr_reg    <= '0;
			refused_reg    <= 1'b0;
			sw_addr_reg    <= '0;
			sw_data_reg    <= 8'h00;
			ack_reg        <= 1'b0;
			rdat_reg       <= 32'h0000_0000;
			out_reg        <= 8'h00;
			oe_reg         <= 1'b0;
		end else begin
			lock_one_reg   <= lock_one_next;
			lock_two_reg   <= lock_two_next;
			pulse_cnt_reg  <= pulse_cnt_next;
			pulse_prev_reg <= pulse_prev_next;
			op_reg         <= op_next;
			op_addr_reg    <= op_addr_next;
			refused_reg    <= refused_next;
			sw_addr_reg    <= sw_addr_next;
			sw_data_reg    <= sw_data_next;
			ack_reg        <= ack_next;
			rdat_reg       <= rdat_next;
			out_reg        <= out_next;
			oe_reg         <= oe_next;
		end
	end

	assign byte_data_port_o    = out_reg;
	assign byte_data_port_oe_o = oe_reg;
	assign wb_ack_o            = ack_reg;
	assign wb_dat_o            = rdat_reg;
endmodule

//--- src/otp_cfg.svh
`ifndef OTP_CFG_SVH
`define OTP_CFG_SVH

// Mode select codes, bits [5:1] of the mode port, highest first
`define OTP_MODE_PROG_CODE  5'h0f
`define OTP_MODE_VERIFY    5'h03
`define OTP_MODE_PROG_ENC  5'h0d
`define OTP_MODE_LOCK_ONE  5'h1f
`define OTP_MODE_LOCK_TWO  5'h1c
`define OTP_MODE_SIGNATURE 5'h00

// Strobe pulse counts per operation
`define OTP_PULSES_CODE    5'd5
`define OTP_PULSES_LOCK    5'd25
`define OTP_PULSES_ENC     5'd25

// Signature locations
`define OTP_SIG_ADDR_MFR   15'h0030
`define OTP_SIG_ADDR_DEV   15'h0060

// Erased value of code and table bytes
`define OTP_ERASED_BYTE    8'h00

// Wishbone register byte addresses
`define OTP_REG_STATUS     4'h0
`define OTP_REG_CONTROL    4'h4
`define OTP_REG_ADDR       4'h8
`define OTP_REG_DATA       4'hc

// Status and control field positions
`define OTP_ST_LOCK_ONE    0
`define OTP_ST_LOCK_TWO    1
`define OTP_ST_REFUSED     2
`define OTP_CTL_READ       0
`define OTP_CTL_REFUSED_CLR 1

`endif

//--- src/otp_pkg.sv
package otp_pkg;
	typedef enum logic [2:0] {
		OTP_OP_NONE,
		OTP_OP_PROG_CODE,
		OTP_OP_VERIFY,
		OTP_OP_PROG_ENC,
		OTP_OP_LOCK_ONE,
		OTP_OP_LOCK_TWO,
		OTP_OP_SIGNATURE
	} otp_op_type;
endpackage

//--- src/otp_pin_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of pin levels
module otp_pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// First stage feeds only the second
	always_comb begin
		meta_next = async_i;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;
endmodule

//--- verif/opvp_sva.sv
`timescale 1ns/100ps
`include "otp_cfg.svh"
// Checker on the pin and bus ports of the port block
module opvp_sva
	import otp_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        prog_reset_i,
	input wire logic [7:0]  addr_low_port_i,
	input wire logic [6:0]  addr_high_port_i,
	input wire logic [5:1]  mode_select_port_i,
	input wire logic        prog_store_strobe_i,
	input wire logic [7:0]  byte_data_port_o,
	input wire logic        byte_data_port_oe_o,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Five samples cover two sync stages plus the output register
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pin_reset_low;
		!prog_reset_i [*5];
	endsequence
	sequence s_strobe_high;
		prog_store_strobe_i [*5];
	endsequence
	sequence s_no_read_mode;
		(mode_select_port_i != `OTP_MODE_VERIFY && mode_select_port_i != `OTP_MODE_SIGNATURE) [*5];
	endsequence
	sequence s_verify_held;
		(prog_reset_i && !prog_store_strobe_i && mode_select_port_i == `OTP_MODE_VERIFY
			&& $stable({addr_high_port_i, addr_low_port_i})) [*6];
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	AST_DAT_HOLD: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("read data moved");
	AST_OE_PIN_RESET: assert property (s_pin_reset_low |-> !byte_data_port_oe_o) else $error("drive without reset pin");
	AST_OE_STROBE: assert property (s_strobe_high |-> !byte_data_port_oe_o) else $error("drive with strobe high");
	AST_OE_MODE: assert property (s_no_read_mode |-> !byte_data_port_oe_o) else $error("drive outside read modes");
	AST_VERIFY_HOLD: assert property (s_verify_held |-> $stable(byte_data_port_o)
		&& $stable(byte_data_port_oe_o)) else $error("verify byte unstable");
endmodule
bind otp_program_verify_port opvp_sva u_sva (.clk_i, .rst_i, .prog_reset_i, .addr_low_port_i, .addr_high_port_i,
	.mode_select_port_i, .prog_store_strobe_i, .byte_data_port_o, .byte_data_port_oe_o, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o);

//--- verif/opvp_programmer.sv
`timescale 1ns/100ps
// Behavioural ROM writer driving the device pins
module opvp_programmer (
	input  wire logic       clk_i,
	input  wire logic [7:0] data_i,
	output logic            prog_reset_o,
	output logic      [7:0] addr_low_o,
	output logic      [6:0] addr_high_o,
	output logic      [7:0] data_o,
	output logic      [5:1] mode_o,
	output logic            strobe_o,
	output logic            pulse_o,
	output logic            hv_o
);
	// Idle: reset pin low, strobes high, no high voltage
	initial begin
		{prog_reset_o, strobe_o, pulse_o, hv_o, mode_o, addr_high_o, addr_low_o, data_o} = {4'h6, 5'h01, 23'h000000};
	end
	// Mode levels, address split over two ports, then settle time
	task automatic setup(input logic [4:0] mode, input logic [14:0] addr, input logic [7:0] data, input logic hv);
		@(posedge clk_i);
		{prog_reset_o, strobe_o, hv_o} <= {1'b1, 1'b0, hv};
		mode_o <= mode;
		{addr_high_o, addr_low_o} <= addr;
		data_o <= data;
		repeat (8) @(posedge clk_i);
	endtask
	// Pulse train; lows and highs kept well over the minimum of one cycle
	task automatic prog(input logic [4:0] mode, input logic [14:0] addr, input logic [7:0] data, input logic hv,
		input int n);
		setup(mode, addr, data, hv);
		repeat (n) begin
			pulse_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			pulse_o <= 1'b1;
			repeat (4) @(posedge clk_i);
		end
		repeat (6) @(posedge clk_i);
		// Released data lines show the inverse, not a stale copy
		{prog_reset_o, strobe_o, hv_o} <= 3'b010;
		data_o <= ~data;
	endtask
	// Read cycle: lines released, byte taken once the device has settled
	task automatic verify(input logic [4:0] mode, input logic [14:0] addr, output logic [7:0] got);
		setup(mode, addr, ~data_o, 1'b0);
		got = data_i;
	endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
`include "otp_cfg.svh"
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  wb_adr = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic        wb_we = 1'b0;
	logic        wb_req = 1'b0;
	logic [31:0] wb_rdat, q;
	logic        wb_ack, oe, pr_rst, strobe, pulse, hv;
	logic [7:0]  dout, pdat, pin_data, alow, got;
	logic [6:0]  ahigh;
	logic [5:1]  mode;
	logic [14:0] va [4] = '{15'h0045, 15'h0085, 15'h4045, 15'h0046};
	logic [7:0]  ve [4] = '{8'h96, 8'h00, 8'h00, 8'hff};
	int          mismatches = 0;
	int          tests_run = 0;
	// Shared data wire: device wins while it drives
	assign pin_data = oe ? dout : pdat;
	always #25 clk_i = ~clk_i;
	otp_program_verify_port #(.MFR_ID(8'h5a), .DEV_ID(8'hc3)) dut (.clk_i, .rst_i, .prog_reset_i(pr_rst),
		.addr_low_port_i(alow), .addr_high_port_i(ahigh), .byte_data_port_i(pin_data), .byte_data_port_o(dout),
		.byte_data_port_oe_o(oe),
		.mode_select_port_i(mode), .prog_store_strobe_i(strobe), .prog_pulse_i(pulse),
		.high_voltage_test_pin_i(hv), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_we_i(wb_we),
		.wb_sel_i(4'hf), .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_ack_o(wb_ack));
	opvp_programmer u_prg (.clk_i, .data_i(pin_data), .prog_reset_o(pr_rst), .addr_low_o(alow),
		.addr_high_o(ahigh), .data_o(pdat), .mode_o(mode), .strobe_o(strobe), .pulse_o(pulse), .hv_o(hv));
	task automatic tally_and_finish;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t byte %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t word %h expected %h", $time, g, e);
		end
	endtask
	// Classic cycle; ack sampled at the edge, bounded wait
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		{wb_req, wb_we, wb_adr, wb_wdat} <= {1'b1, we, adr, d};
		do @(posedge clk_i); while (wb_ack !== 1'b1 && ++i < 20);
		q = wb_rdat;
		wb_req <= 1'b0;
		if (i >= 20) begin
			mismatches++;
			$display("MISMATCH %0t no ack", $time);
			tally_and_finish();
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		chk8({oe, dout[6:0]}, 8'h00);
		rst_i <= 1'b0;
		wb(1'b0, `OTP_REG_STATUS, 32'h0);
		chk32(q, 32'h0);
		wb(1'b0, 4'h6, 32'h0);
		chk32(q, 32'h0);
		wb(1'b1, `OTP_REG_ADDR, 32'h7fff);
		wb(1'b1, `OTP_REG_CONTROL, 32'h1);
		wb(1'b0, `OTP_REG_DATA, 32'h0);
		chk32(q, 32'hff);
		u_prg.verify(`OTP_MODE_VERIFY, 15'h7fff, got);
		chk8(got, 8'hff);
		chk8({7'h0, oe}, 8'h01);
		u_prg.prog(`OTP_MODE_PROG_CODE, 15'h0045, 8'h96, 1'b1, 5);
		u_prg.prog(`OTP_MODE_PROG_ENC, 15'h0005, 8'hff, 1'b1, 25);
		u_prg.prog(`OTP_MODE_PROG_ENC, 15'h0006, 8'h00, 1'b1, 25);
		u_prg.verify(`OTP_MODE_VERIFY, 15'h0106, got);
		chk8(got, 8'hff);
		for (int k = 0; k < 4; k++) begin
			u_prg.verify(`OTP_MODE_VERIFY, va[k], got);
			chk8(got, ve[k]);
		end
		// Programming without high voltage is refused
		u_prg.prog(`OTP_MODE_PROG_CODE, 15'h0046, 8'h3c, 1'b0, 5);
		wb(1'b0, `OTP_REG_STATUS, 32'h0);
		chk32(q, 32'h4);
		wb(1'b1, `OTP_REG_CONTROL, 32'h2);
		u_prg.verify(`OTP_MODE_SIGNATURE, `OTP_SIG_ADDR_MFR, got);
		chk8(got, 8'h5a);
		u_prg.verify(`OTP_MODE_SIGNATURE, `OTP_SIG_ADDR_DEV, got);
		chk8(got, 8'hc3);
		u_prg.prog(`OTP_MODE_LOCK_ONE, 15'h0000, 8'h00, 1'b1, 25);
		u_prg.prog(`OTP_MODE_PROG_CODE, 15'h0046, 8'h3c, 1'b1, 5);
		u_prg.prog(`OTP_MODE_PROG_ENC, 15'h0006, 8'h55, 1'b1, 25);
		wb(1'b0, `OTP_REG_STATUS, 32'h0);
		chk32(q, 32'h5);
		u_prg.verify(`OTP_MODE_VERIFY, 15'h0046, got);
		chk8(got, 8'hff);
		wb(1'b1, `OTP_REG_CONTROL, 32'h2);
		u_prg.prog(`OTP_MODE_LOCK_TWO, 15'h0000, 8'h00, 1'b1, 25);
		wb(1'b0, `OTP_REG_STATUS, 32'h0);
		chk32(q, 32'h3);
		u_prg.verify(`OTP_MODE_VERIFY, 15'h0045, got);
		chk8({7'h0, oe}, 8'h00);
		wb(1'b1, `OTP_REG_ADDR, 32'h0045);
		wb(1'b1, `OTP_REG_CONTROL, 32'h1);
		wb(1'b0, `OTP_REG_DATA, 32'h0);
		chk32(q, 32'h0);
		tally_and_finish();
	end
endmodule
